// file: hw/escr_pkg.sv
package escr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int          ADDR_W                 = 8;
  localparam int          DATA_W                 = 16;
  localparam logic [7:0]  SLOT_SELECT_OFFSET     = 8'h14;
  localparam logic [7:0]  EMITTER3_CONFIG_OFFSET = 8'h22;
  localparam logic [15:0] SLOT_SELECT_RESET      = 16'h0541;
  localparam logic [15:0] EMITTER3_CONFIG_RESET  = 16'h3000;

  // ==========================================================================
  // Slot selection fields
  // ==========================================================================
  localparam int SLOT_B_DIODE_LSB   = 8;
  localparam int SLOT_A_DIODE_LSB   = 4;
  localparam int SLOT_B_EMITTER_LSB = 2;
  localparam int SLOT_A_EMITTER_LSB = 0;
  localparam int DIODE_SEL_W        = 4;
  localparam int EMITTER_SEL_W      = 2;
  localparam int PHOTO_INPUTS       = 4;

  localparam logic [3:0] DIODE_FLOATING  = 4'h0;
  localparam logic [3:0] DIODE_ALL       = 4'h1;
  localparam logic [3:0] DIODE_ONE_FOUR  = 4'h5;

  localparam logic [1:0] EMITTER_NONE  = 2'h0;
  localparam logic [1:0] EMITTER_ONE   = 2'h1;
  localparam logic [1:0] EMITTER_TWO   = 2'h2;
  localparam logic [1:0] EMITTER_THREE = 2'h3;

  // ==========================================================================
  // Third emitter fields
  // ==========================================================================
  localparam int STRENGTH_BIT     = 13;
  localparam int EDGE_RATE_LSB    = 4;
  localparam int EDGE_RATE_W      = 3;
  localparam int COARSE_LSB       = 0;
  localparam int COARSE_W         = 4;
  localparam int FINE_W           = 5;

  // ==========================================================================
  // Peak current factors, fixed point
  // ==========================================================================
  // Coarse and scale in tenths, fine in thousandths: product is in 1e-5 mA
  localparam logic [11:0] COARSE_BASE_X10 = 12'h1f7;  // 50.3
  localparam logic [11:0] COARSE_STEP_X10 = 12'h0c6;  // 19.8
  localparam logic [10:0] FINE_BASE_X1000 = 11'h2e4;  // 0.74
  localparam logic [10:0] FINE_STEP_X1000 = 11'h016;  // 0.022
  localparam logic [3:0]  SCALE_BASE_X10  = 4'h4;     // 0.4
  localparam logic [3:0]  SCALE_STEP_X10  = 4'h6;     // 0.6
  localparam int          PEAK_W          = 27;

  typedef enum logic [1:0] {
    ESCR_SLOT_IDLE = 2'b00,
    ESCR_SLOT_A    = 2'b01,
    ESCR_SLOT_B    = 2'b10
  } escr_slot_t;

endpackage

// file: hw/escr_peak_calc.sv
`timescale 1ns/1ns
module escr_peak_calc (
  input  wire logic                           clock,
  input  wire logic                           arst_n,
  input  wire logic                           clk_en,
  input  wire logic [escr_pkg::COARSE_W-1:0]  coarse_code,
  input  wire logic [escr_pkg::FINE_W-1:0]    fine_code,
  input  wire logic                           strength,
  output logic      [escr_pkg::PEAK_W-1:0]    peak_current
);
  import escr_pkg::*;

  logic [11:0]       coarse_factor;
  logic [10:0]       fine_factor;
  logic [3:0]        scale_factor;
  logic [PEAK_W-1:0] peak_next;

  // ==========================================================================
  // Factors
  // ==========================================================================
  always_comb begin
    coarse_factor = COARSE_BASE_X10 + 12'(COARSE_STEP_X10 * 12'(coarse_code));  // R9
    fine_factor   = FINE_BASE_X1000 + 11'(FINE_STEP_X1000 * 11'(fine_code));    // R10
    scale_factor  = strength ? (SCALE_BASE_X10 + SCALE_STEP_X10) : SCALE_BASE_X10;  // R7
    peak_next     = PEAK_W'(PEAK_W'(coarse_factor) * PEAK_W'(fine_factor) * PEAK_W'(scale_factor));  // R10
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      peak_current <= '0;
    end else if (clk_en) begin
      peak_current <= peak_next;
    end
  end

endmodule

// file: hw/escr_top.sv
`timescale 1ns/1ns
// Behaviour
// (R1) Slot B diode select in bits 11:8: 0 floats all inputs, 1 and 5 connect inputs one to four, reset 5.
// (R2) Slot A diode select in bits 7:4 uses the same codes and resets to 4.
// (R3) Slot B emitter select in bits 3:2: 1 to 3 pulse emitters one to three, 0 pulses only the inputs, reset 0.
// (R4) Slot A emitter select in bits 1:0 uses the same codes and resets to 1.
// (R5) Software keeps bits 15:12 of the slot register at zero.
// (R6) Bit 13 of the third emitter register gives full strength at 1 and low power 40 percent at 0, reset 1.
// (R7) The third emitter strength factor is 0.4 plus 0.6 times the strength bit.
// (R8) Bits 6:4 of the third emitter register set its edge rate from slowest 0 to fastest 7, reset 0.
// (R9) Bits 3:0 set the coarse current code with factor 50.3 plus 19.8 times the code, reset 0.
// (R10) Peak current is coarse times fine times scale, fine being 0.74 plus 0.022 times the fine code.
// (R11) Software writes reserved bits of the third emitter register with their reset values.
// (R12) Slot settings take effect only while their own slot is active.
module escr_top (
  input  wire logic                              clock,
  input  wire logic                              arst_n,
  input  wire logic                              clk_en,
  input  wire logic                              reg_wr_en,
  input  wire logic                              reg_rd_en,
  input  wire logic [escr_pkg::ADDR_W-1:0]       reg_addr,
  input  wire logic [escr_pkg::DATA_W-1:0]       reg_wdata,
  output logic      [escr_pkg::DATA_W-1:0]       reg_rdata,
  output logic                                   reg_rd_valid,
  input  wire logic                              slot_a_active,
  input  wire logic                              slot_b_active,
  input  wire logic [escr_pkg::FINE_W-1:0]       fine_code,
  output logic      [escr_pkg::PHOTO_INPUTS-1:0] photo_inputs_connect,
  output logic                                   emitter_output_one,
  output logic                                   emitter_output_two,
  output logic                                   emitter_output_three,
  output logic                                   afe_pulse_only,
  output logic      [1:0]                        active_slot,
  output logic                                   emitter3_strength,
  output logic      [escr_pkg::EDGE_RATE_W-1:0]  emitter3_edge_rate,
  output logic      [escr_pkg::COARSE_W-1:0]     emitter3_coarse_current,
  output logic      [escr_pkg::PEAK_W-1:0]       emitter3_peak_current
);
  import escr_pkg::*;

  logic [DATA_W-1:0]        slot_select_reg;
  logic [DATA_W-1:0]        emitter3_config_reg;
  logic [DATA_W-1:0]        rdata_next;
  escr_slot_t               slot_next;
  logic [DIODE_SEL_W-1:0]   slot_a_diode_select;
  logic [DIODE_SEL_W-1:0]   slot_b_diode_select;
  logic [EMITTER_SEL_W-1:0] slot_a_emitter_select;
  logic [EMITTER_SEL_W-1:0] slot_b_emitter_select;
  logic [DIODE_SEL_W-1:0]   diode_sel_now;
  logic [EMITTER_SEL_W-1:0] emitter_sel_now;
  logic [PHOTO_INPUTS-1:0]  connect_next;
  logic [2:0]               emitters_next;
  logic                     afe_only_next;

  // ==========================================================================
  // Decoders
  // ==========================================================================
  // Reserved diode codes float every input, the safe choice for the front end
  function automatic logic [PHOTO_INPUTS-1:0] diode_decode(input logic [DIODE_SEL_W-1:0] code);
    case (code)
      DIODE_ALL:      diode_decode = '1;
      DIODE_ONE_FOUR: diode_decode = '1;
      DIODE_FLOATING: diode_decode = '0;
      default:        diode_decode = '0;
    endcase
  endfunction

  function automatic logic [2:0] emitter_decode(input logic [EMITTER_SEL_W-1:0] code);
    case (code)
      EMITTER_ONE:   emitter_decode = 3'h1;
      EMITTER_TWO:   emitter_decode = 3'h2;
      EMITTER_THREE: emitter_decode = 3'h4;
      default:       emitter_decode = 3'h0;
    endcase
  endfunction

  // ==========================================================================
  // Register writes
  // ==========================================================================
  // Words are stored as written; keeping reserved bits clean is left to software
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slot_select_reg <= SLOT_SELECT_RESET;  // R1 R2 R3 R4
    end else if (clk_en && reg_wr_en && reg_addr == SLOT_SELECT_OFFSET) begin
      slot_select_reg <= reg_wdata;  // R5
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      emitter3_config_reg <= EMITTER3_CONFIG_RESET;  // R6 R8 R9
    end else if (clk_en && reg_wr_en && reg_addr == EMITTER3_CONFIG_OFFSET) begin
      emitter3_config_reg <= reg_wdata;  // R11
    end
  end

  // ==========================================================================
  // Register reads
  // ==========================================================================
  always_comb begin
    case (reg_addr)
      SLOT_SELECT_OFFSET:     rdata_next = slot_select_reg;
      EMITTER3_CONFIG_OFFSET: rdata_next = emitter3_config_reg;
      default:                rdata_next = '0;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rd_valid <= 1'b0;
    end else if (clk_en) begin
      reg_rd_valid <= reg_rd_en;
    end
  end

  // Data holds between reads so a slow host may still take it late
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (clk_en && reg_rd_en) begin
      reg_rdata <= rdata_next;
    end
  end

  // ==========================================================================
  // Slot routing
  // ==========================================================================
  assign slot_b_diode_select   = slot_select_reg[SLOT_B_DIODE_LSB +: DIODE_SEL_W];
  assign slot_a_diode_select   = slot_select_reg[SLOT_A_DIODE_LSB +: DIODE_SEL_W];
  assign slot_b_emitter_select = slot_select_reg[SLOT_B_EMITTER_LSB +: EMITTER_SEL_W];
  assign slot_a_emitter_select = slot_select_reg[SLOT_A_EMITTER_LSB +: EMITTER_SEL_W];

  // Slot A wins if the sequencer ever raises both at once
  always_comb begin
    if (slot_a_active) begin
      slot_next = ESCR_SLOT_A;
    end else if (slot_b_active) begin
      slot_next = ESCR_SLOT_B;
    end else begin
      slot_next = ESCR_SLOT_IDLE;
    end
  end

  always_comb begin
    case (slot_next)
      ESCR_SLOT_A: begin
        diode_sel_now   = slot_a_diode_select;  // R2
        emitter_sel_now = slot_a_emitter_select;  // R4
      end
      ESCR_SLOT_B: begin
        diode_sel_now   = slot_b_diode_select;  // R1
        emitter_sel_now = slot_b_emitter_select;  // R3
      end
      default: begin
        diode_sel_now   = DIODE_FLOATING;  // R12
        emitter_sel_now = EMITTER_NONE;
      end
    endcase
    connect_next  = diode_decode(diode_sel_now);
    emitters_next = emitter_decode(emitter_sel_now);
    afe_only_next = (slot_next != ESCR_SLOT_IDLE) && (emitter_sel_now == EMITTER_NONE);  // R3 R4
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      active_slot <= ESCR_SLOT_IDLE;
    end else if (clk_en) begin
      active_slot <= slot_next;  // R12
    end
  end

  // Inputs float at reset so no diode is loaded before a slot first goes active (slot B's reset code 5 connects all four)
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      photo_inputs_connect <= '0;
    end else if (clk_en) begin
      photo_inputs_connect <= connect_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      emitter_output_one   <= 1'b0;
      emitter_output_two   <= 1'b0;
      emitter_output_three <= 1'b0;
    end else if (clk_en) begin
      emitter_output_one   <= emitters_next[0];
      emitter_output_two   <= emitters_next[1];
      emitter_output_three <= emitters_next[2];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      afe_pulse_only <= 1'b0;
    end else if (clk_en) begin
      afe_pulse_only <= afe_only_next;
    end
  end

  // ==========================================================================
  // Third emitter drive
  // ==========================================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      emitter3_strength       <= EMITTER3_CONFIG_RESET[STRENGTH_BIT];
      emitter3_edge_rate      <= EMITTER3_CONFIG_RESET[EDGE_RATE_LSB +: EDGE_RATE_W];
      emitter3_coarse_current <= EMITTER3_CONFIG_RESET[COARSE_LSB +: COARSE_W];
    end else if (clk_en) begin
      emitter3_strength       <= emitter3_config_reg[STRENGTH_BIT];  // R6
      emitter3_edge_rate      <= emitter3_config_reg[EDGE_RATE_LSB +: EDGE_RATE_W];  // R8
      emitter3_coarse_current <= emitter3_config_reg[COARSE_LSB +: COARSE_W];  // R9
    end
  end

  escr_peak_calc u_peak (
    .clock        (clock),
    .arst_n       (arst_n),
    .clk_en       (clk_en),
    .coarse_code  (emitter3_config_reg[COARSE_LSB +: COARSE_W]),
    .fine_code    (fine_code),
    .strength     (emitter3_config_reg[STRENGTH_BIT]),
    .peak_current (emitter3_peak_current)
  );

endmodule

// file: verification/escr_top_assertions.sv
`timescale 1ns/1ns
module escr_top_checker (
  input wire logic                              clock,
  input wire logic                              arst_n,
  input wire logic                              clk_en,
  input wire logic                              reg_wr_en,
  input wire logic                              reg_rd_en,
  input wire logic [escr_pkg::ADDR_W-1:0]       reg_addr,
  input wire logic [escr_pkg::DATA_W-1:0]       reg_wdata,
  input wire logic                              reg_rd_valid,
  input wire logic                              slot_a_active,
  input wire logic                              slot_b_active,
  input wire logic [escr_pkg::FINE_W-1:0]       fine_code,
  input wire logic [escr_pkg::PHOTO_INPUTS-1:0] photo_inputs_connect,
  input wire logic                              emitter_output_one,
  input wire logic                              emitter_output_two,
  input wire logic                              emitter_output_three,
  input wire logic                              afe_pulse_only,
  input wire logic [1:0]                        active_slot,
  input wire logic                              emitter3_strength,
  input wire logic [escr_pkg::EDGE_RATE_W-1:0]  emitter3_edge_rate,
  input wire logic [escr_pkg::COARSE_W-1:0]     emitter3_coarse_current,
  input wire logic [escr_pkg::PEAK_W-1:0]       emitter3_peak_current
);
  import escr_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [1:0]        settle_reg;
  logic [PEAK_W-1:0] peak_exp;
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  // Peak may lag its operands by a stage, so it is judged only after a quiet spell
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) settle_reg <= 2'h0;
    else if (clk_en && settle_reg != 2'h3) settle_reg <= settle_reg + 2'h1;
  end
  assign peak_exp = (27'h1f7 + 27'hc6 * 27'(emitter3_coarse_current)) * (27'h2e4 + 27'h16 * 27'(fine_code))
                    * (emitter3_strength ? 27'ha : 27'h4);
  // ==========================================================================
  // Properties
  // ==========================================================================
  read_valid_pulse_a: assert property (clk_en |=> reg_rd_valid == $past(reg_rd_en))
    else $error("read valid does not follow read strobe");
  e3_follow_a: assert property (clk_en && reg_wr_en && reg_addr == EMITTER3_CONFIG_OFFSET ##1 clk_en
    |=> {2'h0, emitter3_strength, 6'h0, emitter3_edge_rate, emitter3_coarse_current} == ($past(reg_wdata, 2) & 16'h207f))
    else $error("third emitter fields do not follow write");
  e3_reset_a: assert property ($rose(arst_n) |-> emitter3_strength && emitter3_edge_rate == 3'h0
    && emitter3_coarse_current == 4'h0) else $error("third emitter fields wrong after reset");
  peak_formula_a: assert property ((clk_en && $stable(fine_code) && $stable(emitter3_coarse_current)
    && $stable(emitter3_strength))[*3] ##0 settle_reg == 2'h3 |-> emitter3_peak_current == peak_exp)
    else $error("peak current differs from formula");
  slot_a_first_a: assert property (clk_en && slot_a_active |=> active_slot == 2'h1)
    else $error("slot A not reported");
  slot_b_only_a: assert property (clk_en && slot_b_active && !slot_a_active |=> active_slot == 2'h2)
    else $error("slot B not reported");
  idle_quiet_a: assert property (clk_en && !slot_a_active && !slot_b_active |=> active_slot == 2'h0
    && photo_inputs_connect == 4'h0 && !(emitter_output_one || emitter_output_two || emitter_output_three
    || afe_pulse_only)) else $error("outputs active outside slots");
  one_driver_a: assert property (active_slot != 2'h0
    |-> $onehot({emitter_output_one, emitter_output_two, emitter_output_three, afe_pulse_only}))
    else $error("not exactly one emitter choice in slot");
  photo_whole_a: assert property (photo_inputs_connect == 4'h0 || photo_inputs_connect == 4'hf)
    else $error("partial photo input connection");
  cover property (active_slot == 2'h2);
  cover property (reg_rd_valid);
  cover property (afe_pulse_only && active_slot == 2'h2);
  cover property (clk_en && reg_wr_en && reg_addr == EMITTER3_CONFIG_OFFSET);
endmodule

// file: verification/emitter_slot_control_regs_bench.sv
`timescale 1ns/1ns
module emitter_slot_control_regs_bench;
  import escr_pkg::*;
  logic              clock, arst_n, clk_en, reg_wr_en, reg_rd_en, slot_a_active, slot_b_active;
  logic [ADDR_W-1:0] reg_addr;
  logic [15:0]       reg_wdata, reg_rdata, sr, er;
  logic              reg_rd_valid, emitter_output_one, emitter_output_two, emitter_output_three, afe_pulse_only;
  logic [4:0]        fine_code, fc;
  logic [3:0]        photo_inputs_connect, emitter3_coarse_current;
  logic [3:0]        dtab [4];
  logic [1:0]        active_slot;
  logic              emitter3_strength;
  logic [2:0]        emitter3_edge_rate;
  logic [26:0]       emitter3_peak_current;
  integer            seed;
  int                fails, n_tests;

  escr_top DUT (.clock, .arst_n, .clk_en, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rd_valid, .slot_a_active, .slot_b_active, .fine_code, .photo_inputs_connect, .emitter_output_one,
    .emitter_output_two, .emitter_output_three, .afe_pulse_only, .active_slot, .emitter3_strength,
    .emitter3_edge_rate, .emitter3_coarse_current, .emitter3_peak_current);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ==========================================================================
  // Checks and expectations
  // ==========================================================================
  task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk_out(input string what, input logic [26:0] exp, input logic [26:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  function automatic logic [26:0] slot_exp(input logic [3:0] dio, input logic [1:0] em, input logic [1:0] slot);
    return {17'h0, slot, (dio == 4'h1 || dio == 4'h5) ? 4'hf : 4'h0, em == 2'h1, em == 2'h2, em == 2'h3, em == 2'h0};
  endfunction
  function automatic logic [26:0] peak_of(input logic [3:0] c, input logic [4:0] f, input logic s);
    return (27'h1f7 + 27'hc6 * 27'(c)) * (27'h2e4 + 27'h16 * 27'(f)) * (s ? 27'ha : 27'h4);
  endfunction
  // ==========================================================================
  // Drivers
  // ==========================================================================
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    @(negedge clock);
    chk_reg("read valid", 16'h1, {15'h0, reg_rd_valid});
    chk_reg("read data", exp, reg_rdata);
  endtask
  task automatic slot_run(input logic a, input logic b, input logic [26:0] exp);
    @(posedge clock);
    slot_a_active <= a;
    slot_b_active <= b;
    @(posedge clock);
    @(negedge clock);
    chk_out("slot outputs", exp, {17'h0, active_slot, photo_inputs_connect, emitter_output_one,
      emitter_output_two, emitter_output_three, afe_pulse_only});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    conclude();
  end
  initial begin
    seed = 32'h5343;
    {arst_n, reg_wr_en, reg_rd_en, slot_a_active, slot_b_active} = 5'h0;
    clk_en = 1'b1;
    reg_addr = 8'h0;
    reg_wdata = 16'h0;
    fine_code = 5'h0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    rd(SLOT_SELECT_OFFSET, 16'h0541);
    rd(EMITTER3_CONFIG_OFFSET, 16'h3000);
    rd(8'h15, 16'h0);
    chk_out("reset peak", peak_of(4'h0, 5'h0, 1'b1), emitter3_peak_current);
    slot_run(1'b1, 1'b0, slot_exp(4'h4, 2'h1, 2'h1));
    slot_run(1'b0, 1'b1, slot_exp(4'h5, 2'h0, 2'h2));
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      dtab = '{4'h0, 4'h1, 4'h5, 4'($random(seed))};
      sr = {4'h0, dtab[(i / 4) % 4], dtab[i % 4], 2'(i >> 2), 2'(i)};
      er = (i == 0) ? 16'h307f : (i == 1) ? 16'h1000 : {2'h0, 1'($random(seed)), 6'h20, 7'($random(seed))};
      fc = (i == 0) ? 5'h1f : 5'($random(seed));
      wr(SLOT_SELECT_OFFSET, sr);
      wr(EMITTER3_CONFIG_OFFSET, er);
      fine_code <= fc;
      rd(SLOT_SELECT_OFFSET, sr);
      rd(EMITTER3_CONFIG_OFFSET, er);
      slot_run(1'b1, 1'b0, slot_exp(sr[7:4], sr[1:0], 2'h1));
      slot_run(1'b0, 1'b1, slot_exp(sr[11:8], sr[3:2], 2'h2));
      slot_run(1'b1, 1'b1, slot_exp(sr[7:4], sr[1:0], 2'h1));
      slot_run(1'b0, 1'b0, 27'h0);
      chk_out("emitter3 fields", {19'h0, er[13], er[6:4], er[3:0]},
        {19'h0, emitter3_strength, emitter3_edge_rate, emitter3_coarse_current});
      chk_out("peak", peak_of(er[3:0], fc, er[13]), emitter3_peak_current);
    end
    $display("test random settings done");
    wr(8'h15, 16'hffff);
    @(posedge clock);
    clk_en <= 1'b0;
    wr(SLOT_SELECT_OFFSET, 16'h0000);
    clk_en <= 1'b1;
    rd(SLOT_SELECT_OFFSET, sr);
    rd(8'h15, 16'h0);
    $display("test ignored writes done");
    conclude();
  end
endmodule

bind escr_top escr_top_checker u_checker (.clock, .arst_n, .clk_en, .reg_wr_en, .reg_rd_en, .reg_addr,
  .reg_wdata, .reg_rd_valid, .slot_a_active, .slot_b_active, .fine_code, .photo_inputs_connect,
  .emitter_output_one, .emitter_output_two, .emitter_output_three, .afe_pulse_only, .active_slot,
  .emitter3_strength, .emitter3_edge_rate, .emitter3_coarse_current, .emitter3_peak_current);
